//--- dynamic_clock_switch_ctrl.sv
// dynamic clock switch controller with a protected command register
// assumes a classic wishbone master on clk_i and static fuse inputs
// Notes on behaviour
// - reset takes the system clock source from the source choice fuses.
// - switch accepts RC, watchdog oscillator, external clock, crystal, PLL/4.
// - an enabled source runs its start-up count before being usable.
// - availability request reports the chosen source status in command register.
// - no clock and clock not yet ready both read as not ready.
// - a valid write of the code field delivers that command once.
// - unlock step writes only the unlock bit set, all else zero.
// - the new value is accepted within four cycles with unlock cleared.
// - codes 0 and 1xxx do nothing; 1 disable, 2 enable, 3 request, 4 switch.
// - code 5 recovers current source code; code 7 applies clock output.
// - bit 7 of the selection register always reads zero.
// - clock output select loads from the clock output fuse at reset.
// - output select acts only on clock output command; recover keeps it.
// - start-up time field loads from the start-up fuses at reset.
// - enable uses the start-up time field for the source; disable stops it unless it is the current system source.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`include "clock_switch_params.svh"
module dynamic_clock_switch_ctrl #(
    parameter int NSRC = `NUM_SOURCES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [3:0]  source_choice_fuses_i,
    input  wire logic [1:0]  startup_fuses_i,
    input  wire logic        output_clock_fuse_i,
    input  wire logic [NSRC-1:0] source_alive_i,
    output logic      [NSRC-1:0] source_enable_o,
    output logic      [3:0]  system_source_o,
    output logic             clock_out_enable_o
);
    import clock_switch_pkg::*;

    // ============================================================
    // state
    clock_switch_pkg::sel_reg_type sel_q;
    clock_switch_pkg::unlock_state_type ustate_q;
    logic [3:0]      code_q;
    logic [2:0]      window_q;
    logic [3:0]      current_q;
    logic [3:0]      query_q;
    logic            clk_out_q;
    logic            ack_q;
    logic [31:0]     rdata_q;
    logic [NSRC-1:0] alive_s;
    logic [NSRC-1:0] ready_w;
    logic [NSRC-1:0] start_w;
    logic [NSRC-1:0] stop_w;

    // ============================================================
    // bus decode
    wire        access_w   = cyc_i && stb_i && !ack_q;
    wire        lane_w     = sel_i[0];
    wire        hit_cmd_w  = (adr_i == `CMD_REG_OFFSET);
    wire        hit_sel_w  = (adr_i == `SEL_REG_OFFSET);
    wire        wr_cmd_w   = access_w && we_i && lane_w && hit_cmd_w;
    wire        wr_sel_w   = access_w && we_i && lane_w && hit_sel_w;
    wire [7:0]  wbyte_w    = dat_i[7:0];
    wire        unlock_w   = wr_cmd_w && (wbyte_w == `CMD_UNLOCK_VALUE);
    wire        window_w   = (ustate_q == UNLOCKED) && (window_q != 3'h0);
    wire        accept_w   = wr_cmd_w && window_w && !wbyte_w[`CMD_UNLOCK_BIT];
    wire        execute_w  = (ustate_q == EXECUTE);
    wire [3:0]  src_w      = sel_q.source;
    wire        src_ok_w   = (src_w < 4'(NSRC));
    wire [NSRC-1:0] src_bit_w = NSRC'(1) << src_w;
    wire        is_dis_w   = execute_w && (code_q == `CODE_DISABLE);
    wire        is_en_w    = execute_w && (code_q == `CODE_ENABLE);
    wire        is_req_w   = execute_w && (code_q == `CODE_REQUEST);
    wire        is_sw_w    = execute_w && (code_q == `CODE_SWITCH);
    wire        is_rec_w   = execute_w && (code_q == `CODE_RECOVER);
    wire        is_co_w    = execute_w && (code_q == `CODE_CLKOUT);
    wire        target_rdy = src_ok_w && ready_w[src_w[2:0]];
    wire        flag_w     = (query_q < 4'(NSRC)) && ready_w[query_q[2:0]];
    wire [7:0]  cmd_rd_w   = {window_w, 2'b00, flag_w, code_q};
    wire [7:0]  sel_rd_w   = {1'b0, sel_q.clk_out, sel_q.startup, sel_q.source};

    // ============================================================
    // wishbone slave: one wait state, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= access_w;
            rdata_q <= hit_cmd_w ? {24'h00_0000, cmd_rd_w} :
                       hit_sel_w ? {24'h00_0000, sel_rd_w} : 32'h0000_0000;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // ============================================================
    // protected command write: unlock, then one write inside the window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ustate_q <= LOCKED;
            window_q <= 3'h0;
        end else begin
            case (ustate_q)
                LOCKED: begin
                    if (unlock_w) begin
                        ustate_q <= UNLOCKED;
                        window_q <= `UNLOCK_WINDOW;
                    end
                end
                UNLOCKED: begin
                    if (accept_w) begin
                        ustate_q <= EXECUTE;
                        window_q <= 3'h0;
                    end else if (unlock_w) begin
                        window_q <= `UNLOCK_WINDOW;
                    end else if (window_q == 3'h1) begin
                        ustate_q <= LOCKED;
                        window_q <= 3'h0;
                    end else begin
                        window_q <= window_q - 3'h1;
                    end
                end
                EXECUTE: begin
                    ustate_q <= LOCKED;
                end
                default: begin
                    ustate_q <= LOCKED;
                    window_q <= 3'h0;
                end
            endcase
        end
    end

    // command code holds its value; only the protected write changes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_q <= `CODE_NONE;
        end else if (accept_w) begin
            code_q <= wbyte_w[`CMD_CODE_MSB:`CMD_CODE_LSB];
        end
    end

    // ============================================================
    // selection register: fuses at reset, software writes, recover
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q.reserved <= 1'b0;
            sel_q.clk_out  <= output_clock_fuse_i;
            sel_q.startup  <= startup_fuses_i;
            sel_q.source   <= source_choice_fuses_i;
        end else if (is_rec_w) begin
            sel_q.source   <= current_q;
        end else if (wr_sel_w) begin
            sel_q.reserved <= 1'b0;
            sel_q.clk_out  <= wbyte_w[`SEL_CLKOUT_BIT];
            sel_q.startup  <= wbyte_w[`SEL_STARTUP_MSB:`SEL_STARTUP_LSB];
            sel_q.source   <= wbyte_w[`SEL_SOURCE_MSB:`SEL_SOURCE_LSB];
        end
    end

    // ============================================================
    // command execution
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_q <= source_choice_fuses_i;
            query_q   <= source_choice_fuses_i;
            clk_out_q <= 1'b0;
        end else begin
            if (is_sw_w && target_rdy) begin
                current_q <= src_w;
            end
            if ((is_req_w || is_en_w) && src_ok_w) begin
                query_q <= src_w;
            end
            if (is_co_w) begin
                clk_out_q <= sel_q.clk_out;
            end
        end
    end

    assign system_source_o    = current_q;
    assign clock_out_enable_o = clk_out_q;

    // ============================================================
    // per-source start-up timers
    level_sync #(
        .WIDTH(NSRC)
    ) alive_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .async_i(source_alive_i),
        .sync_o (alive_s)
    );

    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : gen_src
            assign start_w[g] = is_en_w && (src_w == 4'(g));
            assign stop_w[g]  = is_dis_w && (src_w == 4'(g)) && (current_q != 4'(g));
            startup_timer timer (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .start_i  (start_w[g]),
                .stop_i   (stop_w[g]),
                .code_i   (sel_q.startup),
                .alive_i  (alive_s[g]),
                .enabled_o(source_enable_o[g]),
                .ready_o  (ready_w[g])
            );
        end
    endgenerate

    // ============================================================
    // checks
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && !we_i && $past(hit_sel_w)) |-> !dat_o[7])
        else $error("reserved selection bit read as one");

    a_window_closes: assert property (@(posedge clk_i) disable iff (rst_i)
        (unlock_w && ustate_q == LOCKED) |-> ##[1:5] ((ustate_q != UNLOCKED) || unlock_w))
        else $error("unlock window stayed open too long");

    a_code_guarded: assert property (@(posedge clk_i) disable iff (rst_i)
        (code_q != $past(code_q)) |-> $past(accept_w))
        else $error("command code changed without unlock");

    a_switch_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        (current_q != $past(current_q)) |-> $past(is_sw_w && target_rdy))
        else $error("switched to a source that was not ready");

    a_recover_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(is_rec_w) |-> (sel_q.clk_out == $past(sel_q.clk_out)) && (sel_q.source == $past(current_q)))
        else $error("recover command disturbed the output select");

    a_clkout_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        (clock_out_enable_o != $past(clock_out_enable_o)) |-> $past(is_co_w))
        else $error("clock output changed outside its command");

    a_fuse_load: assert property (@(posedge clk_i)
        $past(rst_i) |-> (sel_q.clk_out == $past(output_clock_fuse_i))
                      && (sel_q.startup == $past(startup_fuses_i)))
        else $error("fuses not loaded at reset");

    a_enable_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_en_w && src_ok_w) |=> !ready_w[src_w[2:0]])
        else $error("source ready without start-up count");

    a_locked_stays: assert property (@(posedge clk_i) disable iff (rst_i)
        (ustate_q == LOCKED && !unlock_w) |=> (ustate_q == LOCKED))
        else $error("window opened without the unlock write");

    a_accept_recent: assert property (@(posedge clk_i) disable iff (rst_i)
        accept_w |-> ($past(unlock_w, 1) || $past(unlock_w, 2) || $past(unlock_w, 3) || $past(unlock_w, 4)))
        else $error("command accepted outside the four cycle window");

    a_unlock_reads: assert property (@(posedge clk_i) disable iff (rst_i)
        unlock_w |=> cmd_rd_w[`CMD_UNLOCK_BIT])
        else $error("unlock bit not shown after unlock write");

    a_exec_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        execute_w |-> $past(accept_w))
        else $error("command executed without an accepted write");

    a_exec_once: assert property (@(posedge clk_i) disable iff (rst_i)
        execute_w |=> !execute_w)
        else $error("command delivered more than once");

    a_code_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        accept_w |=> (code_q == $past(wbyte_w[`CMD_CODE_MSB:`CMD_CODE_LSB])))
        else $error("accepted code not stored");

    a_none_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (execute_w && ((code_q == `CODE_NONE) || code_q[3]))
        |=> $stable(source_enable_o) && $stable(system_source_o) && $stable(clock_out_enable_o))
        else $error("no-command code changed an output");

    a_enable_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_en_w && src_ok_w) |=> ((source_enable_o & $past(src_bit_w)) == $past(src_bit_w)))
        else $error("enable command did not enable the source");

    a_disable_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_dis_w && src_ok_w && (src_w != current_q)) |=> ((source_enable_o & $past(src_bit_w)) == '0))
        else $error("disable command did not stop the source");

    a_current_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_dis_w && (src_w == current_q)) |=> $stable(source_enable_o))
        else $error("running system source was stopped");

    a_request_query: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_req_w && src_ok_w) |=> (query_q == $past(src_w)))
        else $error("request did not select the reported source");

    a_switch_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_sw_w && target_rdy) |=> (system_source_o == $past(src_w)))
        else $error("switch to a ready source not taken");

    a_switch_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_sw_w && !target_rdy) |=> $stable(system_source_o))
        else $error("switch to a source that was not ready taken");

    a_ready_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
        ((ready_w & ~source_enable_o) == '0))
        else $error("disabled source reads ready");

    a_ready_alive: assert property (@(posedge clk_i) disable iff (rst_i)
        ((ready_w & ~alive_s) == '0))
        else $error("silent source reads ready");

    a_recover_startup: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(is_rec_w) |-> (sel_q.startup == $past(sel_q.startup)))
        else $error("recover command disturbed the start-up field");

    a_clkout_value: assert property (@(posedge clk_i) disable iff (rst_i)
        is_co_w |=> (clock_out_enable_o == $past(sel_q.clk_out)))
        else $error("clock output command applied a wrong value");

    a_source_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> (system_source_o == $past(source_choice_fuses_i)))
        else $error("system source not taken from the fuses at reset");

    a_ack_after_take: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("bus request not answered after one wait state");

    a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> (dat_o[31:8] == 24'h00_0000))
        else $error("read data above the low byte not zero");
endmodule

//--- clock_switch_params.svh
// constants for the dynamic clock switch controller: offsets, fields, codes, timing
// assumes a 25 MHz system clock and a classic wishbone register port
`ifndef CLOCK_SWITCH_PARAMS_SVH
`define CLOCK_SWITCH_PARAMS_SVH

// ============================================================
// register byte offsets
`define CMD_REG_OFFSET      4'h0
`define SEL_REG_OFFSET      4'h4

// ============================================================
// command register fields
`define CMD_UNLOCK_BIT      7
`define CMD_READY_BIT       4
`define CMD_CODE_MSB        3
`define CMD_CODE_LSB        0
`define CMD_UNLOCK_VALUE    8'h80

// ============================================================
// selection register fields
`define SEL_CLKOUT_BIT      6
`define SEL_STARTUP_MSB     5
`define SEL_STARTUP_LSB     4
`define SEL_SOURCE_MSB      3
`define SEL_SOURCE_LSB      0

// ============================================================
// command codes
`define CODE_NONE           4'h0
`define CODE_DISABLE        4'h1
`define CODE_ENABLE         4'h2
`define CODE_REQUEST        4'h3
`define CODE_SWITCH         4'h4
`define CODE_RECOVER        4'h5
`define CODE_CLKOUT         4'h7

// ============================================================
// sources and reset values
`define NUM_SOURCES         5
`define CMD_RESET           8'h00
`define UNLOCK_WINDOW       3'h4

// ============================================================
// start-up times per start-up code, in ns, and cycle counts at 40 ns
`define CLK_PERIOD_NS       40
`define STARTUP_T0_NS       400
`define STARTUP_T1_NS       4000
`define STARTUP_T2_NS       40000
`define STARTUP_T3_NS       160000
`define NS_TO_CYCLES(t)     ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

//--- clock_switch_pkg.sv
// types shared by the clock switch controller files
// assumes clock_switch_params.svh is on the include path
`include "clock_switch_params.svh"

package clock_switch_pkg;

    typedef struct packed {
        logic       reserved;
        logic       clk_out;
        logic [1:0] startup;
        logic [3:0] source;
    } sel_reg_type;

    typedef enum logic [1:0] {
        LOCKED,
        UNLOCKED,
        EXECUTE
    } unlock_state_type;

    // start-up code to a cycle count, rounded up
    function automatic logic [12:0] startup_cycles(input logic [1:0] code);
        logic [12:0] n;
        n = 13'h0001;
        case (code)
            2'h0:    n = 13'(`NS_TO_CYCLES(`STARTUP_T0_NS));
            2'h1:    n = 13'(`NS_TO_CYCLES(`STARTUP_T1_NS));
            2'h2:    n = 13'(`NS_TO_CYCLES(`STARTUP_T2_NS));
            default: n = 13'(`NS_TO_CYCLES(`STARTUP_T3_NS));
        endcase
        return n;
    endfunction

endpackage

//--- level_sync.sv
// two-stage synchroniser for levels arriving from other clocks
// assumes each bit is a slow level; the first stage feeds only the second
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= '0;
            sync_o  <= '0;
        end else begin
            stage_q <= async_i;
            sync_o  <= stage_q;
        end
    end
endmodule

//--- startup_timer.sv
// start-up counter for one clock source
// assumes start/stop are one-cycle pulses and alive_i is already synchronised
module startup_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       stop_i,
    input  wire logic [1:0] code_i,
    input  wire logic       alive_i,
    output logic            enabled_o,
    output logic            ready_o
);
    import clock_switch_pkg::*;

    logic [12:0] count_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enabled_o <= 1'b0;
            count_q   <= 13'h0000;
        end else if (stop_i) begin
            enabled_o <= 1'b0;
            count_q   <= 13'h0000;
        end else if (start_i) begin
            enabled_o <= 1'b1;
            count_q   <= startup_cycles(code_i);
        end else if (count_q != 13'h0000) begin
            count_q   <= count_q - 13'h0001;
        end
    end

    // a dead source and one still starting both read not ready
    assign ready_o = enabled_o && (count_q == 13'h0000) && alive_i;
endmodule

//--- dynamic_clock_switch_ctrl_tb.sv
// self-checking bench for the dynamic clock switch controller
// assumes the design's default source count and a 25 MHz clock; fuses are static levels
module dynamic_clock_switch_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [3:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  source_choice_fuses_i;
    logic [1:0]  startup_fuses_i;
    logic        output_clock_fuse_i;
    logic [4:0]  source_alive_i;
    logic [4:0]  source_enable_o;
    logic [3:0]  system_source_o;
    logic        clock_out_enable_o;
    int          bad_count;
    int          n_tests;
    logic [7:0]  rd;

    dynamic_clock_switch_ctrl DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .source_choice_fuses_i(source_choice_fuses_i), .startup_fuses_i(startup_fuses_i),
        .output_clock_fuse_i(output_clock_fuse_i), .source_alive_i(source_alive_i),
        .source_enable_o(source_enable_o), .system_source_o(system_source_o),
        .clock_out_enable_o(clock_out_enable_o)
    );

    // ============================================================
    // clock, reset, watchdog
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = 4'h0; sel_i = 4'h0; dat_i = 32'h0;
        source_choice_fuses_i = 4'h0;
        startup_fuses_i = 2'h0;
        output_clock_fuse_i = 1'b1;
        // sources 0 and 1 oscillate, source 2 is dead
        source_alive_i = 5'b00011;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_unprot();
        t_enable();
        t_switch();
        t_request();
        t_disable();
        t_recover();
        t_clkout();
        t_window();
        t_refuse();
        end_sim();
    end

    // whole run is well under 2000 cycles
    initial begin
        repeat (6000) @(posedge clk_i);
        bad_count++;
        end_sim();
    end

    // ============================================================
    // helpers
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // classic single wishbone cycle; ack sampled at the rising edge
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= we; adr_i <= a; sel_i <= 4'hf; dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, 8'h01, 8'h00);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    // unlock then command at minimal spacing, then let the command land
    task automatic prot(input logic [7:0] v);
        wr(4'h0, 8'h80);
        wr(4'h0, v);
        repeat (3) @(posedge clk_i);
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        wb(1'b0, 4'h4, 8'h0, rd);
        chk(8'h40, rd);
        chk(8'h00, rd & 8'h30);
        chk(8'h00, {4'h0, system_source_o});
        chk(8'h00, {3'h0, source_enable_o});
        chk(8'h00, {7'h0, clock_out_enable_o});
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h00, rd);
        wb(1'b0, 4'h8, 8'h0, rd);
        chk(8'h00, rd);
        $display("reset test done");
    endtask

    task automatic t_unprot();
        wr(4'h0, 8'h02);
        repeat (3) @(posedge clk_i);
        chk(8'h00, {3'h0, source_enable_o});
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h00, rd);
        $display("unprotected write test done");
    endtask

    task automatic t_enable();
        wr(4'h4, 8'h01);
        prot(8'h02);
        chk(8'h02, {3'h0, source_enable_o});
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h02, rd);
        // start-up code 0 is 10 cycles, plus two synchroniser flops
        repeat (20) @(posedge clk_i);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h12, rd);
        wr(4'h4, 8'h02);
        prot(8'h02);
        repeat (40) @(posedge clk_i);
        chk(8'h06, {3'h0, source_enable_o});
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h02, rd);
        $display("enable test done");
    endtask

    task automatic t_switch();
        wr(4'h4, 8'h02);
        prot(8'h04);
        chk(8'h00, {4'h0, system_source_o});
        wr(4'h4, 8'h01);
        prot(8'h04);
        chk(8'h01, {4'h0, system_source_o});
        $display("switch test done");
    endtask

    task automatic t_request();
        wr(4'h4, 8'h01);
        prot(8'h03);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h13, rd);
        wr(4'h4, 8'h02);
        prot(8'h03);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h03, rd);
        $display("request test done");
    endtask

    task automatic t_disable();
        wr(4'h4, 8'h02);
        prot(8'h01);
        chk(8'h02, {3'h0, source_enable_o});
        // the running system source must not be stopped
        wr(4'h4, 8'h01);
        prot(8'h01);
        chk(8'h02, {3'h0, source_enable_o});
        $display("disable test done");
    endtask

    task automatic t_recover();
        wr(4'h4, 8'hc3);
        wb(1'b0, 4'h4, 8'h0, rd);
        chk(8'h43, rd);
        chk(8'h00, {7'h0, clock_out_enable_o});
        prot(8'h05);
        wb(1'b0, 4'h4, 8'h0, rd);
        chk(8'h41, rd);
        $display("recover test done");
    endtask

    task automatic t_clkout();
        prot(8'h07);
        chk(8'h01, {7'h0, clock_out_enable_o});
        wr(4'h4, 8'h01);
        prot(8'h07);
        chk(8'h00, {7'h0, clock_out_enable_o});
        $display("clock output test done");
    endtask

    task automatic t_window();
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h80);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h80, rd & 8'h80);
        repeat (4) @(posedge clk_i);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h00, rd & 8'h80);
        wr(4'h0, 8'h02);
        repeat (3) @(posedge clk_i);
        chk(8'h02, {3'h0, source_enable_o});
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h07, rd & 8'h0f);
        // a code of the 1xxx group does nothing
        prot(8'h0a);
        chk(8'h02, {3'h0, source_enable_o});
        chk(8'h01, {4'h0, system_source_o});
        $display("window test done");
    endtask

    // second reset in mid-run with other fuse values; start-up code 1 is 100 cycles
    task automatic t_refuse();
        @(posedge clk_i);
        rst_i                 <= 1'b1;
        source_choice_fuses_i <= 4'h2;
        startup_fuses_i       <= 2'h1;
        output_clock_fuse_i   <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h4, 8'h0, rd);
        chk(8'h12, rd);
        chk(8'h02, {4'h0, system_source_o});
        chk(8'h00, {3'h0, source_enable_o});
        wr(4'h4, 8'h10);
        prot(8'h02);
        repeat (20) @(posedge clk_i);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h02, rd);
        repeat (100) @(posedge clk_i);
        wb(1'b0, 4'h0, 8'h0, rd);
        chk(8'h12, rd);
        $display("fuse reset test done");
    endtask
endmodule
